// >>> hdl/cascade_defs.svh
// Constants of the cascade staging block: register offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef CASCADE_DEFS_SVH
`define CASCADE_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define REG_CTRL 5'h00
`define REG_ACT_THR 5'h04
`define REG_OVR_THR 5'h08
`define REG_ACT_DLY 5'h0c
`define REG_DEACT_DLY 5'h10
`define REG_INTERLOCK 5'h14
`define REG_SWITCH_SPEED 5'h18
`define REG_STATUS 5'h1c

// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_CODE_LSB 4
`define CTRL_MODE_LSB 8
`define CODE_MAX 4'h8

// Reset values of the writable settings
`define RST_ACT_THR 16'h0400
`define RST_OVR_THR 16'h1000
`define RST_ACT_DLY 16'h03e8
`define RST_DEACT_DLY 16'h03e8
`define RST_INTERLOCK 16'h07d0
`define RST_SWITCH_SPEED 16'h4000

// Timing: clock period and the millisecond timer tick
`define CLK_PERIOD_NS 10
`define TICK_TIME_NS 1000000

`endif

// >>> hdl/cascade_pkg.sv
// Types shared by the cascade staging design files.
// Assumes the constants header is included by the files that need numbers.
package cascade_pkg;

    // Staging controller states, one-hot
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_INTERLOCK = 6'h02,
        ST_WATCH = 6'h04,
        ST_DELAY_UP = 6'h08,
        ST_DELAY_DOWN = 6'h10,
        ST_RAMP = 6'h20
    } stage_state_t;

    // Whole state of the staging controller
    typedef struct packed {
        stage_state_t st;
        logic [2:0] stage_mask;
        logic [1:0] rot;
        logic [2:0] motor_out;
        logic ramp_up;
        logic enable;
        logic [3:0] code;
        logic [1:0] mode;
        logic [15:0] act_thr;
        logic [15:0] ovr_thr;
        logic [15:0] act_dly;
        logic [15:0] deact_dly;
        logic [15:0] interlock;
        logic [15:0] switch_speed;
        logic ack;
        logic [31:0] rdata;
        logic [19:0] prescale;
        logic tick;
    } cascade_regs_t;

    // Whole state of a millisecond down-counter
    typedef struct packed {
        logic [15:0] count;
    } timer_regs_t;

endpackage : cascade_pkg

// >>> hdl/cascade_staging.sv
// Cascade staging controller: adds and removes up to three fixed-speed motors.
// Assumes deviation and speed flags synchronous to sys_clk; software over Avalon-MM.
// Notes on behaviour
// - Process controller deviation decides staging.
// - Each motor has its own digital output.
// - At max speed, rising deviation adds motor.
// - Adding a motor ramps main drive down.
// - Controller held while ramping to switch speed.
// - At most three external motors on.
// - At min speed, falling deviation removes motor.
// - Interlock time blocks every further change except a disable.
// - Above overcontrol threshold: switch at once.
// - Between thresholds: wait activation delay first.
// - Removal uses same interlock and thresholds, own deactivation delay.
// - Sequence setting fixes switching order.
// - Code 0 off; codes 1-8 fixed lists.
// - Status bits 0-2 drive outputs 0-2.
// - Selection mode: fixed order or hours-based.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cascade_defs.svh"
module cascade_staging #(
    parameter int TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic signed [15:0] pid_deviation,
    input wire logic at_max_speed,
    input wire logic at_min_speed,
    input wire logic ramp_done,
    output logic [2:0] motor_out,
    output logic ctrl_hold,
    output logic ramp_to_switch,
    output logic ramp_up,
    output logic [15:0] switch_speed
);
    // ************************************************
    // Declarations
    // ************************************************
    localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1); // Last prescaler count

    // Known state after reset: motors off, settings at defaults
    localparam cascade_pkg::cascade_regs_t REG_RESET = '{
        st: cascade_pkg::ST_OFF,
        stage_mask: 3'h0,
        rot: 2'h0,
        motor_out: 3'h0,
        ramp_up: 1'b0,
        enable: 1'b0,
        code: 4'h0,
        mode: 2'h0,
        act_thr: `RST_ACT_THR,
        ovr_thr: `RST_OVR_THR,
        act_dly: `RST_ACT_DLY,
        deact_dly: `RST_DEACT_DLY,
        interlock: `RST_INTERLOCK,
        switch_speed: `RST_SWITCH_SPEED,
        ack: 1'b0,
        rdata: 32'h00000000,
        prescale: 20'h00000,
        tick: 1'b0
    };

    logic [1:0] rst_sync; // Reset release synchroniser
    logic rst_n; // Synchronised reset, active low
    cascade_pkg::cascade_regs_t r; // Registered state
    cascade_pkg::cascade_regs_t n; // Next state

    // Timers
    logic il_start; // Load the interlock timer
    logic il_done; // Interlock expired
    logic dl_start; // Load the staging delay timer
    logic [15:0] dl_load; // Delay for the direction in question
    logic dl_done; // Staging delay expired

    // Sequence lookup
    logic [2:0] next_up; // Next combination up the sequence
    logic [2:0] next_down; // Next combination down the sequence
    logic can_up; // Sequence has a further level

    // Decisions
    logic go_up; // Stage up this cycle
    logic go_down; // Stage down this cycle
    logic staging_ok; // Staging allowed by the settings
    logic up_cond; // Activation threshold passed at max speed
    logic up_now; // Overcontrol threshold passed at max speed
    logic down_cond; // Negative activation threshold passed at min speed
    logic down_now; // Negative overcontrol threshold passed at min speed

    // ************************************************
    // Helper functions
    // ************************************************
    // Deviation above a positive threshold (low 15 bits used)
    function automatic logic dev_above(input logic signed [15:0] d, input logic [15:0] t);
        return d > $signed({1'b0, t[14:0]});
    endfunction : dev_above

    // Deviation below the negated threshold
    function automatic logic dev_below(input logic signed [15:0] d, input logic [15:0] t);
        return d < -$signed({1'b0, t[14:0]});
    endfunction : dev_below

    // Map logical motors onto outputs, rotated for wear sharing
    function automatic logic [2:0] rotate_mask(input logic [2:0] m, input logic [1:0] k);
        logic [2:0] o;
        case (k)
            2'h1: o = {m[1:0], m[2]};
            2'h2: o = {m[0], m[2:1]};
            default: o = m;
        endcase
        return o;
    endfunction : rotate_mask

    // ************************************************
    // Reset release
    // ************************************************
    // Assert at once, release two edges later so all flops leave reset together
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ************************************************
    // Sub-blocks
    // ************************************************
    // Next combinations for the chosen sequence code
    // Pure lookup, answers in the same cycle
    stage_sequence u_seq (
        .code(r.code),
        .mask(r.stage_mask),
        .next_up(next_up),
        .next_down(next_down),
        .can_up(can_up)
    );

    // Interlock after every change
    stage_timer u_interlock (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(il_start),
        .load(r.interlock),
        .tick(r.tick),
        .done(il_done)
    );

    // Activation or deactivation delay
    // One timer: only one delay runs at a time
    stage_timer u_delay (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(dl_start),
        .load(dl_load),
        .tick(r.tick),
        .done(dl_done)
    );

    // ************************************************
    // Threshold decisions
    // ************************************************
    // Codes above the highest defined one are treated as off
    assign staging_ok = r.enable && r.code != 4'h0 && r.code <= `CODE_MAX;
    assign up_cond = at_max_speed && dev_above(pid_deviation, r.act_thr);
    assign up_now = at_max_speed && dev_above(pid_deviation, r.ovr_thr);
    // Removal mirrors addition, thresholds negated
    assign down_cond = at_min_speed && dev_below(pid_deviation, r.act_thr);
    assign down_now = at_min_speed && dev_below(pid_deviation, r.ovr_thr);

    // ************************************************
    // Next state: bus slave, prescaler, staging sequence
    // ************************************************
    always_comb begin
        n = r;
        il_start = 1'b0;
        dl_start = 1'b0;
        dl_load = r.act_dly;
        go_up = 1'b0;
        go_down = 1'b0;

        // Millisecond tick for both timers
        n.tick = (r.prescale == TICK_LAST);
        n.prescale = n.tick ? 20'h00000 : r.prescale + 20'h00001;

        // One wait cycle per access; the answer is registered
        n.ack = (avs_read || avs_write) && !r.ack;
        if (avs_read && !r.ack) begin
            // Loaded at the first edge, stands while waitrequest is low
            case (avs_address)
                `REG_CTRL: n.rdata = {22'h000000, r.mode, r.code, 3'h0, r.enable};
                `REG_ACT_THR: n.rdata = {16'h0000, r.act_thr};
                `REG_OVR_THR: n.rdata = {16'h0000, r.ovr_thr};
                `REG_ACT_DLY: n.rdata = {16'h0000, r.act_dly};
                `REG_DEACT_DLY: n.rdata = {16'h0000, r.deact_dly};
                `REG_INTERLOCK: n.rdata = {16'h0000, r.interlock};
                `REG_SWITCH_SPEED: n.rdata = {16'h0000, r.switch_speed};
                // Outputs in bits 2:0, then levels, rotation, state
                `REG_STATUS: n.rdata = {16'h0000, r.st, r.rot, r.ramp_up, r.stage_mask, 1'b0, r.motor_out};
                default: n.rdata = 32'h00000000;
            endcase
        end
        // Writes land at the edge where waitrequest is low
        if (avs_write && r.ack) begin
            case (avs_address)
                `REG_CTRL: begin
                    n.enable = avs_writedata[`CTRL_EN_BIT];
                    n.code = avs_writedata[`CTRL_CODE_LSB +: 4];
                    n.mode = avs_writedata[`CTRL_MODE_LSB +: 2];
                end
                // Settings keep the low half only
                `REG_ACT_THR: n.act_thr = avs_writedata[15:0];
                `REG_OVR_THR: n.ovr_thr = avs_writedata[15:0];
                `REG_ACT_DLY: n.act_dly = avs_writedata[15:0];
                `REG_DEACT_DLY: n.deact_dly = avs_writedata[15:0];
                `REG_INTERLOCK: n.interlock = avs_writedata[15:0];
                `REG_SWITCH_SPEED: n.switch_speed = avs_writedata[15:0];
                // Status and unmapped words ignore writes
                default: n.enable = r.enable;
            endcase
        end

        // Staging sequence
        case (r.st)
            // Off: every motor released, waiting for enable
            cascade_pkg::ST_OFF: begin
                // First motor needs no interlock
                if (staging_ok) begin
                    n.st = cascade_pkg::ST_WATCH;
                end
            end

            // Watch: demand up or down
            cascade_pkg::ST_WATCH: begin
                if (up_cond && can_up) begin
                    go_up = up_now;
                    if (!up_now) begin
                        n.st = cascade_pkg::ST_DELAY_UP;
                        dl_start = 1'b1;
                    end
                end else if (down_cond && r.stage_mask != 3'h0) begin
                    go_down = down_now;
                    if (!down_now) begin
                        n.st = cascade_pkg::ST_DELAY_DOWN;
                        dl_start = 1'b1;
                        dl_load = r.deact_dly;
                    end
                end
            end

            cascade_pkg::ST_DELAY_UP: begin
                // Demand gone: drop the delay and look again
                if (!up_cond) begin
                    n.st = cascade_pkg::ST_WATCH;
                end else begin
                    go_up = up_now || dl_done;
                end
            end

            // Mirror of the activation delay
            cascade_pkg::ST_DELAY_DOWN: begin
                if (!down_cond) begin
                    n.st = cascade_pkg::ST_WATCH;
                end else begin
                    go_down = down_now || dl_done;
                end
            end

            cascade_pkg::ST_RAMP: begin
                // Controller stays held until the drive reports switch speed
                if (ramp_done) begin
                    n.st = cascade_pkg::ST_INTERLOCK;
                end
            end

            cascade_pkg::ST_INTERLOCK: begin
                // No staging change before the interlock runs out; only a disable still drops the motors
                if (il_done) begin
                    n.st = cascade_pkg::ST_WATCH;
                end
            end

            // Lost state: fall back to off
            default: n.st = cascade_pkg::ST_OFF;
        endcase

        // A change switches a motor, starts the ramp and the interlock
        if (go_up || go_down) begin
            n.stage_mask = go_up ? next_up : next_down;
            n.ramp_up = go_down;
            n.st = cascade_pkg::ST_RAMP;
            il_start = 1'b1;
            // Hours mode: move the order on when the last motor is staged off (not on a disable), spreading run time
            if (go_down && next_down == 3'h0 && r.mode != 2'h0) begin
                n.rot = (r.rot == 2'h2) ? 2'h0 : r.rot + 2'h1;
            end
        end

        // Disabled staging drops every motor at once
        // No ramp: nothing is left to balance
        if (!staging_ok) begin
            n.st = cascade_pkg::ST_OFF;
            n.stage_mask = 3'h0;
            n.ramp_up = 1'b0;
        end

        // Outputs follow the level in the same cycle, from flops
        n.motor_out = rotate_mask(n.stage_mask, n.rot);
    end

    // Single register stage for all state
    // Asynchronous assert, release through rst_sync
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= REG_RESET;
        end else begin
            r <= n;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
    assign avs_readdata = r.rdata;

    // Contactor commands from flops: no glitch reaches a starter
    assign motor_out = r.motor_out;
    // Hold and ramp request both decode the ramp state
    assign ctrl_hold = (r.st == cascade_pkg::ST_RAMP);
    assign ramp_to_switch = (r.st == cascade_pkg::ST_RAMP);

    assign ramp_up = r.ramp_up;
    assign switch_speed = r.switch_speed;
endmodule : cascade_staging
`default_nettype wire

// >>> hdl/stage_sequence.sv
// Lookup of the next motor combination up or down for a sequence code.
// Assumes code 1..8; masks carry motor one in bit 0, motor three in bit 2.
`timescale 1ns/1ps
`default_nettype none
module stage_sequence (
    input wire logic [3:0] code,
    input wire logic [2:0] mask,
    output logic [2:0] next_up,
    output logic [2:0] next_down,
    output logic can_up
);
    // Six levels per code, level one in the low bits; zero marks an empty level
    function automatic logic [17:0] seq_table(input logic [3:0] c, input logic down);
        logic [17:0] t;
        t = 18'h00000;
        case ({down, c})
            5'h01: t = {15'h0000, 3'h1};
            5'h02: t = {12'h000, 3'h3, 3'h1};
            5'h03: t = {9'h000, 3'h3, 3'h2, 3'h1};
            5'h04: t = {9'h000, 3'h7, 3'h3, 3'h1};
            5'h05: t = {6'h00, 3'h7, 3'h5, 3'h4, 3'h1};
            5'h06: t = {3'h0, 3'h7, 3'h6, 3'h3, 3'h2, 3'h1};
            5'h07: t = {3'h0, 3'h7, 3'h5, 3'h4, 3'h3, 3'h1};
            5'h08: t = {3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1};
            5'h11: t = {15'h0000, 3'h1};
            5'h12: t = {12'h000, 3'h1, 3'h3};
            5'h13: t = {9'h000, 3'h1, 3'h2, 3'h3};
            5'h14: t = {9'h000, 3'h1, 3'h3, 3'h7};
            5'h15: t = {6'h00, 3'h1, 3'h4, 3'h5, 3'h7};
            5'h16: t = {3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
            5'h17: t = {3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
            5'h18: t = {3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
            default: t = 18'h00000;
        endcase
        return t;
    endfunction : seq_table

    // Number of motors in a combination
    function automatic logic [1:0] motor_count(input logic [2:0] m);
        return 2'(m[0]) + 2'(m[1]) + 2'(m[2]);
    endfunction : motor_count

    // ************************************************
    // Step after the current combination, or nearest by count
    // ************************************************
    always_comb begin
        logic [17:0] ta;
        logic [17:0] td;
        logic fa;
        logic fd;
        logic [2:0] ea;
        logic [2:0] ed;
        ea = 3'h0;
        ed = 3'h0;
        ta = seq_table(code, 1'b0);
        td = seq_table(code, 1'b1);
        fa = 1'b0;
        fd = 1'b0;
        next_up = 3'h0;
        next_down = 3'h0;
        for (int i = 0; i < 6; i++) begin
            ea = ta[3*i +: 3];
            ed = td[3*i +: 3];
            // Mask not in the list: first level with more, or fewer, motors
            if (!fa && ea != 3'h0 && (ea == mask || motor_count(ea) > motor_count(mask))) begin
                fa = 1'b1;
                next_up = ea;
                if (ea == mask) begin
                    // Past the last level the shift leaves zero
                    next_up = 3'(ta >> (3 * (i + 1)));
                end
            end
            if (!fd && ed != 3'h0 && (ed == mask || motor_count(ed) < motor_count(mask))) begin
                fd = 1'b1;
                next_down = ed;
                if (ed == mask) begin
                    next_down = 3'(td >> (3 * (i + 1)));
                end
            end
        end
        if (mask == 3'h0) begin
            next_up = ta[2:0];
            next_down = 3'h0;
        end
        can_up = (next_up != 3'h0);
    end
endmodule : stage_sequence
`default_nettype wire

// >>> hdl/stage_timer.sv
// Millisecond down-counter used for the interlock and the staging delays.
// Assumes a one-cycle tick per millisecond and a synchronised active-low reset.
`timescale 1ns/1ps
`default_nettype none
module stage_timer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [15:0] load,
    input wire logic tick,
    output logic done
);
    cascade_pkg::timer_regs_t r; // Registered state
    cascade_pkg::timer_regs_t n; // Next state

    // ************************************************
    // Count down once per tick, reload on start
    // ************************************************
    always_comb begin
        n = r;
        if (start) begin
            n.count = load;
        end else if (tick && r.count != 16'h0000) begin
            n.count = r.count - 16'h0001;
        end
    end

    // Idle at zero after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Expired; a start in this cycle hides the old value
    assign done = (r.count == 16'h0000) && !start;
endmodule : stage_timer
`default_nettype wire

// >>> testbench/cascade_sva.sv
// Port checker for the cascade staging block.
// Assumes a bind to cascade_staging; nrst low resets everything.
`timescale 1ns/1ps
`default_nettype none
module cascade_sva (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic at_max_speed,
    input wire logic at_min_speed,
    input wire logic ramp_done,
    input wire logic [2:0] motor_out,
    input wire logic ctrl_hold,
    input wire logic ramp_to_switch,
    input wire logic ramp_up
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Count-based, so any motor rotation still checks
    sequence added;
        $countones(motor_out) > $countones($past(motor_out));
    endsequence
    // Removal under a ramp; a plain disable drops motors without one
    sequence removed;
        ctrl_hold && $countones(motor_out) < $countones($past(motor_out));
    endsequence
    sequence hold_end;
        ctrl_hold ##1 !ctrl_hold;
    endsequence
    AST_HOLD_PAIR: assert property ($rose(ctrl_hold) |-> ramp_to_switch && $changed(motor_out))
        else $error("hold without change");
    AST_ADD_DOWN: assert property (added |-> ctrl_hold && !ramp_up) else $error("add without ramp down");
    AST_ADD_MAX: assert property (added |-> $past(at_max_speed)) else $error("add below max speed");
    AST_DROP_UP: assert property (removed |-> ramp_up && $past(at_min_speed)) else $error("bad removal");
    AST_FREEZE: assert property ($past(ctrl_hold) && ctrl_hold |-> $stable(motor_out)) else $error("ramp change");
    AST_HOLD_END: assert property (ctrl_hold && ramp_done |=> !ctrl_hold) else $error("hold stuck");
    AST_INTERLOCK: assert property (hold_end |-> $stable(motor_out) [*2]) else $error("no interlock");
    AST_RESET: assert property ($rose(nrst) |-> motor_out == 3'h0 && !ctrl_hold) else $error("unclean reset");
endmodule : cascade_sva
bind cascade_staging cascade_sva chk (.sys_clk(sys_clk), .nrst(nrst), .at_max_speed(at_max_speed),
    .at_min_speed(at_min_speed), .ramp_done(ramp_done), .motor_out(motor_out), .ctrl_hold(ctrl_hold),
    .ramp_to_switch(ramp_to_switch), .ramp_up(ramp_up));
`default_nettype wire

// >>> testbench/drive_ramp_model.sv
// Main drive model: reports arrival at the switch speed.
// Assumes ramp_to_switch from the staging block on the same clock.
`timescale 1ns/1ps
`default_nettype none
module drive_ramp_model #(
    parameter int RAMP_CYCLES = 5
) (
    input wire logic sys_clk,
    input wire logic ramp_to_switch,
    output logic ramp_done
);
    int cnt = 0; // Cycles spent ramping
    // Fixed ramp time; arrival flag drops once the request is released
    always @(posedge sys_clk) begin
        cnt <= ramp_to_switch ? cnt + 1 : 0;
        ramp_done <= ramp_to_switch && cnt >= RAMP_CYCLES;
    end
endmodule : drive_ramp_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the cascade staging block.
// Assumes a 10-cycle timer tick and the drive ramp model.
`timescale 1ns/1ps
`default_nettype none
`include "cascade_defs.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic signed [15:0] pid_deviation = 16'sh0;
    logic at_max_speed = 1'b0;
    logic at_min_speed = 1'b0;
    logic ramp_done, ctrl_hold, ramp_to_switch, ramp_up;
    logic [2:0] motor_out;
    logic [15:0] switch_speed;
    logic [31:0] rd; // Last read data
    int n_fail = 0;
    int compares = 0;
    int cyc = 0; // Clock count
    int last = 0; // Cycle of the last motor change
    cascade_staging #(.TICK_CYCLES(10)) uut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pid_deviation(pid_deviation),
        .at_max_speed(at_max_speed), .at_min_speed(at_min_speed), .ramp_done(ramp_done),
        .motor_out(motor_out), .ctrl_hold(ctrl_hold), .ramp_to_switch(ramp_to_switch),
        .ramp_up(ramp_up), .switch_speed(switch_speed));
    drive_ramp_model ramp (.sys_clk(sys_clk), .ramp_to_switch(ramp_to_switch), .ramp_done(ramp_done));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One Avalon access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic drive(input logic mx, input logic mn, input logic signed [15:0] d);
        @(posedge sys_clk);
        at_max_speed <= mx;
        at_min_speed <= mn;
        pid_deviation <= d;
    endtask : drive
    task automatic cfg(input logic [3:0] c);
        bus(1'b1, `REG_CTRL, {24'h0, c, 4'h1});
    endtask : cfg
    // Next motor change (or none, when exp equals the present mask), spacing, ramp end, status
    task automatic step(input logic [2:0] exp, input int gap);
        logic [2:0] was;
        int n;
        was = motor_out;
        n = 0;
        while (motor_out === was && n < 150) begin
            @(negedge sys_clk);
            n++;
        end
        check("motor_out", exp, motor_out);
        if (exp !== was) begin
            check("gap", 1, cyc - last >= gap);
            last = cyc;
        end
        while (ctrl_hold !== 1'b0 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        bus(1'b0, `REG_STATUS, 32'h0);
        check("status", exp, rd[2:0]);
    endtask : step
    task automatic test_reset;
        check("motors", 3'h0, motor_out);
        bus(1'b0, `REG_INTERLOCK, 32'h0);
        check("interlock", `RST_INTERLOCK, rd);
        bus(1'b1, `REG_STATUS, 32'h7);
        bus(1'b0, `REG_STATUS, 32'h0);
        check("status", 32'h0400, rd);
        bus(1'b0, 5'h1d, 32'h0);
        check("unmapped", 32'h0, rd);
        bus(1'b1, `REG_SWITCH_SPEED, 32'h1234);
        @(negedge sys_clk);
        check("speed", 16'h1234, switch_speed);
        bus(1'b1, `REG_ACT_THR, 32'h0100);
        bus(1'b1, `REG_OVR_THR, 32'h0400);
        bus(1'b1, `REG_ACT_DLY, 32'h3);
        bus(1'b1, `REG_DEACT_DLY, 32'h3);
        bus(1'b1, `REG_INTERLOCK, 32'h3);
    endtask : test_reset
    // Every sequence code: disabled, first level, second level or refusal
    task automatic test_codes;
        logic [2:0] lvl2 [8] = '{3'h1, 3'h3, 3'h2, 3'h3, 3'h4, 3'h2, 3'h3, 3'h2};
        drive(1'b1, 1'b0, 16'sh0500);
        for (int c = 1; c <= 8; c++) begin
            cfg(4'h0);
            step(3'h0, 0);
            cfg(c[3:0]);
            step(3'h1, 0);
            step(lvl2[c - 1], 20);
        end
    endtask : test_codes
    // Code 8 up to the cap with both paths, then all the way down
    task automatic test_updown;
        logic [2:0] dn [6] = '{3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
        cfg(4'h0);
        cfg(4'h8);
        drive(1'b1, 1'b0, 16'sh0080);
        step(3'h0, 0);
        drive(1'b1, 1'b0, 16'sh0200);
        step(3'h1, 0);
        step(3'h2, 40);
        drive(1'b1, 1'b0, 16'sh0500);
        for (int i = 4; i < 8; i++) step(i[2:0], 20);
        step(3'h7, 0);
        drive(1'b0, 1'b1, -16'sh0500);
        step(dn[0], 20);
        drive(1'b0, 1'b1, -16'sh0200);
        step(dn[1], 40);
        drive(1'b0, 1'b1, -16'sh0500);
        for (int i = 2; i < 6; i++) step(dn[i], 20);
    endtask : test_updown
    // Hours mode: after a full stop the first motor moves on by one output
    task automatic test_rotate;
        bus(1'b1, `REG_CTRL, 32'h00000111);
        drive(1'b1, 1'b0, 16'sh0500);
        step(3'h1, 20);
        drive(1'b0, 1'b1, -16'sh0500);
        step(3'h0, 20);
        drive(1'b1, 1'b0, 16'sh0500);
        step(3'h2, 20);
    endtask : test_rotate
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        test_reset;
        test_codes;
        test_updown;
        test_rotate;
        test_done;
    end
    // Hang guard, well past the expected run
    initial begin
        #300us;
        n_fail++;
        test_done;
    end
endmodule : testbench
`default_nettype wire
